// *** hw/dpdg_builder.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "dpdg_cfg.svh"

module dpdg_builder #(
    parameter logic [15:0] MAKER_ID = 16'h1234, // Arbitrary value, set per product
    parameter int CLASS1_LAST = `DPDG_CLASS1_LAST,
    parameter int CLASS2_LAST = `DPDG_CLASS2_LAST
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [31:0] rd_data_out,
    // Device state
    input wire dpdg_pkg::dpdg_evt_t evt_in,
    input wire logic [7:0] prm_master_addr_in,
    input wire logic not_ready_in,
    input wire logic wd_active_in,
    input wire logic internal_err_in,
    input wire dpdg_pkg::dpdg_ext_t ext_in,
    // Telegram request and stream
    input wire logic diag_req_in,
    input wire logic tx_ready_in,
    output dpdg_pkg::dpdg_tx_t tx_out,
    output logic pos_data_en_out
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    // The fixed field map only reaches byte 57; the telegram cap is 241
    if (CLASS2_LAST > `DPDG_CLASS2_LAST || CLASS2_LAST > `DPDG_TELEGRAM_MAX ||
        CLASS1_LAST <= `DPDG_GEN_BYTES || CLASS1_LAST > CLASS2_LAST) begin : g_bad_len
        $error("dpdg_builder: telegram lengths out of range");
    end

    localparam logic [5:0] LAST1 = 6'(CLASS1_LAST);
    localparam logic [5:0] LAST2 = 6'(CLASS2_LAST);
    localparam logic [5:0] GEN_BYTES = 6'(`DPDG_GEN_BYTES);

    // ****************************************
    // Declarations
    // ****************************************
    logic class2_reg; // Class 2 layout selected
    logic vendor_reg; // Vendor configuration selected
    logic prm_fault_reg; // Last parameter telegram refused
    logic cfg_fault_reg; // Configuration identifiers refused
    logic not_supp_reg; // Unsupported function asked for
    logic sync_reg; // SYNC received
    logic freeze_reg; // FREEZE received
    logic prm_req_reg; // New parameterization needed
    logic err_reg; // Internal error latched
    logic ext_pend_reg; // Extended report waiting
    logic overflow_reg; // Extended diagnosis overran
    logic [7:0] master_addr_reg; // Parameterizing master
    logic err_clr; // Software clear of the error latch
    logic sent_done; // Telegram fully handed over
    logic [7:0] stat1; // Station status 1
    logic [7:0] stat2; // Station status 2
    logic [7:0] stat3; // Station status 3
    logic [47:0] gen_reg; // General part frozen at request
    logic [5:0] tel_last_reg; // Last byte number of this telegram
    logic [5:0] idx_reg; // Byte number now on the stream
    logic [`DPDG_FRAME_BITS-1:0] frame; // Whole telegram, byte 1 on top
    logic [`DPDG_EXT_BITS-1:0] ext_vec; // Extended part, cleaned
    dpdg_pkg::dpdg_ext_t ext_clean; // Extended fields with reserved bits zeroed
    dpdg_pkg::dpdg_state_t state_reg; // Framer state
    logic [5:0] cur_last; // Last byte for the selected class
    logic [7:0] len_byte; // Byte seven value

    // ****************************************
    // Register port
    // ****************************************
    // Error clear is a write-one pulse, no storage
    assign err_clr = wr_en_in && addr_in == `DPDG_REG_CTRL && wr_data_in[`DPDG_CTRL_ERR_CLR];

    // Configuration bits written by software
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            class2_reg <= 1'b0;
            vendor_reg <= 1'b0;
        end else if (wr_en_in && addr_in == `DPDG_REG_CTRL) begin
            class2_reg <= wr_data_in[`DPDG_CTRL_CLASS2];
            vendor_reg <= wr_data_in[`DPDG_CTRL_VENDOR];
        end
    end

    // Read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_out <= 32'h0000_0000;
        end else if (rd_en_in) begin
            case (addr_in)
                `DPDG_REG_CTRL: begin
                    rd_data_out <= {30'h0000_0000, vendor_reg, class2_reg};
                end
                `DPDG_REG_STATUS: begin
                    rd_data_out <= {master_addr_reg, stat3, stat2, stat1};
                end
                `DPDG_REG_IDENT: begin
                    rd_data_out <= {16'h0000, MAKER_ID};
                end
                `DPDG_REG_LENGTH: begin
                    rd_data_out <= {20'h0_0000, state_reg, err_reg, ext_pend_reg,
                                    len_byte};
                end
                default: begin
                    // Unmapped reads as zero
                    rd_data_out <= 32'h0000_0000;
                end
            endcase
        end else begin
            rd_data_out <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Station status flags
    // ****************************************
    // Every flag below lets a set in the same cycle win over its clear

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prm_fault_reg <= 1'b0;
        end else if (evt_in.prm_reject) begin
            prm_fault_reg <= 1'b1;
        end else if (evt_in.prm_accept) begin
            prm_fault_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cfg_fault_reg <= 1'b0;
        end else if (evt_in.cfg_reject) begin
            cfg_fault_reg <= 1'b1;
        end else if (evt_in.cfg_accept) begin
            cfg_fault_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            not_supp_reg <= 1'b0;
        end else if (evt_in.unsupported) begin
            not_supp_reg <= 1'b1;
        end else if (sent_done) begin
            not_supp_reg <= 1'b0;
        end
    end

    // sync and freeze modes; a new parameterization drops them
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync_reg <= 1'b0;
            freeze_reg <= 1'b0;
        end else begin
            if (evt_in.sync_cmd) begin
                sync_reg <= 1'b1;
            end else if (evt_in.prm_accept) begin
                sync_reg <= 1'b0;
            end
            if (evt_in.freeze_cmd) begin
                freeze_reg <= 1'b1;
            end else if (evt_in.prm_accept) begin
                freeze_reg <= 1'b0;
            end
        end
    end

    // parameterization request: set from reset and on any refusal
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prm_req_reg <= 1'b1;
        end else if (evt_in.prm_reject || evt_in.cfg_reject) begin
            prm_req_reg <= 1'b1;
        end else if (evt_in.prm_accept) begin
            prm_req_reg <= 1'b0;
        end
    end

    // error latch, cleared by software only once the cause is gone
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            err_reg <= 1'b0;
        end else if (internal_err_in) begin
            err_reg <= 1'b1;
        end else if (err_clr) begin
            err_reg <= 1'b0;
        end
    end

    // extended report pending after parameterization or error
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ext_pend_reg <= 1'b0;
        end else if (evt_in.prm_accept || internal_err_in || evt_in.ext_overflow) begin
            ext_pend_reg <= 1'b1;
        end else if (sent_done && !err_reg) begin
            ext_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            overflow_reg <= 1'b0;
        end else if (evt_in.ext_overflow) begin
            overflow_reg <= 1'b1;
        end else if (sent_done) begin
            overflow_reg <= 1'b0;
        end
    end

    // master address taken only with a valid parameterization
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            master_addr_reg <= `DPDG_MASTER_NONE;
        end else if (evt_in.prm_accept) begin
            master_addr_reg <= prm_master_addr_in;
        end
    end

    // position data withheld while the error stands
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pos_data_en_out <= 1'b0;
        end else begin
            pos_data_en_out <= !err_reg && !internal_err_in && !prm_req_reg;
        end
    end

    // ****************************************
    // Status byte assembly
    // ****************************************
    // Master-owned bits go out as zero; the master fills them in
    always_comb begin
        stat1 = 8'h00;
        stat2 = 8'h00;
        stat3 = 8'h00;
        stat1[`DPDG_S1_PRM_FAULT] = prm_fault_reg;
        stat1[`DPDG_S1_NOT_SUPP] = not_supp_reg;
        // pending or error shows extended diagnosis
        stat1[`DPDG_S1_EXT_DIAG] = ext_pend_reg || err_reg;
        stat1[`DPDG_S1_CFG_FAULT] = cfg_fault_reg;
        stat1[`DPDG_S1_NOT_READY] = not_ready_in || prm_req_reg || err_reg;
        stat2[`DPDG_S2_SYNC] = sync_reg;
        stat2[`DPDG_S2_FREEZE] = freeze_reg;
        stat2[`DPDG_S2_WD_ON] = wd_active_in;
        stat2[`DPDG_S2_SLAVE_ST] = 1'b1;
        stat2[`DPDG_S2_STAT_DIAG] = err_reg;
        stat2[`DPDG_S2_PRM_REQ] = prm_req_reg;
        // only the overflow bit may be set
        stat3[`DPDG_S3_OVERFLOW] = overflow_reg;
    end

    // ****************************************
    // Telegram assembly
    // ****************************************
    // length follows the selected class
    assign cur_last = (class2_reg || vendor_reg) ? LAST2 : LAST1;
    // bytes after the general part, length byte included
    assign len_byte = {2'b00, tel_last_reg - GEN_BYTES};

    always_comb begin
        ext_clean = ext_in;
        ext_clean.alarms = ext_in.alarms & `DPDG_ALARM_MASK;
        ext_clean.add_alarms = 8'h00;
    end
    assign ext_vec = ext_clean;

    // fields stacked first byte highest, MSB first
    // general part, then length, then extension
    assign frame = {gen_reg, len_byte, ext_vec};

    // identifier high byte ahead of low byte
    // General part frozen when a telegram starts
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            gen_reg <= 48'h0000_0000_0000;
            tel_last_reg <= 6'h00;
        end else if (state_reg == dpdg_pkg::DPDG_IDLE && diag_req_in) begin
            gen_reg <= {stat1, stat2, stat3, master_addr_reg, MAKER_ID};
            tel_last_reg <= cur_last;
        end
    end

    // Byte n of the telegram, n counted from one
    function automatic logic [7:0] pick(input logic [`DPDG_FRAME_BITS-1:0] f,
                                        input logic [5:0] n);
        logic [8:0] base;
        base = 9'(`DPDG_FRAME_BITS) - {n, 3'b000};
        pick = f[base +: 8];
    endfunction

    // ****************************************
    // Stream framer
    // ****************************************
    // Bytes are picked from live fields; only the general part and the length are frozen,
    // so a field may change between two telegrams but never inside one header
    assign sent_done = state_reg == dpdg_pkg::DPDG_DONE;

    // bytes streamed up to the end of the class latched at the request
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= dpdg_pkg::DPDG_IDLE;
            idx_reg <= 6'h00;
            tx_out <= '0;
        end else begin
            case (state_reg)
                dpdg_pkg::DPDG_IDLE: begin
                    // First byte appears the cycle after the request
                    if (diag_req_in) begin
                        state_reg <= dpdg_pkg::DPDG_SEND;
                        idx_reg <= 6'h01;
                        tx_out.valid <= 1'b1;
                        tx_out.last <= 1'b0;
                        tx_out.data <= stat1;
                    end
                end
                dpdg_pkg::DPDG_SEND: begin
                    if (tx_ready_in) begin
                        if (idx_reg == tel_last_reg) begin
                            // Final byte taken
                            state_reg <= dpdg_pkg::DPDG_DONE;
                            tx_out <= '0;
                        end else begin
                            idx_reg <= idx_reg + 6'h01;
                            tx_out.data <= pick(frame, idx_reg + 6'h01);
                            tx_out.last <= (idx_reg + 6'h01) == tel_last_reg;
                        end
                    end
                end
                dpdg_pkg::DPDG_DONE: begin
                    // One cycle to clear report-once flags
                    state_reg <= dpdg_pkg::DPDG_IDLE;
                    idx_reg <= 6'h00;
                end
                default: begin
                    state_reg <= dpdg_pkg::DPDG_IDLE;
                    tx_out <= '0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// *** hw/dpdg_cfg.svh ***
`ifndef DPDG_CFG_SVH
`define DPDG_CFG_SVH

// Telegram layout, counted in bytes; the EXT and FRAME sizes in bits
`define DPDG_GEN_BYTES 6
`define DPDG_CLASS1_LAST 16
`define DPDG_CLASS2_LAST 57
`define DPDG_TELEGRAM_MAX 241
`define DPDG_EXT_BITS 400
`define DPDG_FRAME_BITS 456

// Station status 1 bit positions
`define DPDG_S1_PRM_FAULT 6
`define DPDG_S1_NOT_SUPP 4
`define DPDG_S1_EXT_DIAG 3
`define DPDG_S1_CFG_FAULT 2
`define DPDG_S1_NOT_READY 1

// Station status 2 bit positions
`define DPDG_S2_SYNC 5
`define DPDG_S2_FREEZE 4
`define DPDG_S2_WD_ON 3
`define DPDG_S2_SLAVE_ST 2
`define DPDG_S2_STAT_DIAG 1
`define DPDG_S2_PRM_REQ 0

// Station status 3 bit positions
`define DPDG_S3_OVERFLOW 7

// Alarm byte: only bits 4..0 are in use
`define DPDG_ALARM_MASK 8'h1f

// Master address before any valid parameterization
`define DPDG_MASTER_NONE 8'hff

// Register offsets
`define DPDG_REG_CTRL 8'h00
`define DPDG_REG_STATUS 8'h04
`define DPDG_REG_IDENT 8'h08
`define DPDG_REG_LENGTH 8'h0c

// Control register fields
`define DPDG_CTRL_CLASS2 0
`define DPDG_CTRL_VENDOR 1
`define DPDG_CTRL_ERR_CLR 2

`endif

// *** hw/dpdg_pkg.sv ***
package dpdg_pkg;

    // Framer states, Gray coded along idle -> send -> done
    typedef enum logic [1:0] {
        DPDG_IDLE = 2'b00,
        DPDG_SEND = 2'b01,
        DPDG_DONE = 2'b11
    } dpdg_state_t;

    // Extended diagnosis fields, bytes 8..57, first byte first
    typedef struct packed {
        logic [7:0] alarms;
        logic [7:0] op_status;
        logic [7:0] enc_type;
        logic [31:0] resolution;
        logic [15:0] revolutions;
        logic [7:0] add_alarms;
        logic [15:0] alarms_supp;
        logic [15:0] warnings;
        logic [15:0] warn_supp;
        logic [15:0] profile_ver;
        logic [15:0] sw_ver;
        logic [31:0] hours;
        logic [31:0] offset;
        logic [31:0] mfr_offset;
        logic [31:0] steps;
        logic [31:0] range;
        logic [79:0] serial;
    } dpdg_ext_t;

    // Protocol events from the bus state machine
    typedef struct packed {
        logic prm_accept;
        logic prm_reject;
        logic cfg_accept;
        logic cfg_reject;
        logic unsupported;
        logic sync_cmd;
        logic freeze_cmd;
        logic ext_overflow;
    } dpdg_evt_t;

    // Outgoing telegram byte stream
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } dpdg_tx_t;

endpackage

// *** verification/dpdg_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****
// Telegram stream checker
// ****
module dpdg_assertions #(
    parameter logic [15:0] MAKER_ID = 16'h1234
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic [7:0] addr_in,
    input wire logic rd_en_in,
    input wire logic [31:0] rd_data_out,
    input wire dpdg_pkg::dpdg_evt_t evt_in,
    input wire logic internal_err_in,
    input wire logic diag_req_in,
    input wire logic tx_ready_in,
    input wire dpdg_pkg::dpdg_tx_t tx_out,
    input wire logic pos_data_en_out
);
    logic [5:0] idx_reg; // Byte index in frame
    logic done_reg; // Cycle after last handshake
    wire logic hs = tx_out.valid && tx_ready_in;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);
    // Index wraps on last byte, so a lost last shows
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            idx_reg <= 6'h00;
            done_reg <= 1'b0;
        end else begin
            done_reg <= hs && tx_out.last;
            if (hs) begin
                idx_reg <= tx_out.last ? 6'h00 : idx_reg + 6'h01;
            end
        end
    end
    sequence s_taken;
        diag_req_in && !tx_out.valid && !done_reg;
    endsequence
    sequence s_last_hs;
        hs && tx_out.last;
    endsequence
    a_req_first_byte: assert property (s_taken |=> tx_out.valid && idx_reg == 6'h00)
        else $error("no first byte");
    a_byte_holds: assert property (tx_out.valid && !tx_ready_in |=> $stable(tx_out))
        else $error("byte moved");
    a_done_gap: assert property (s_last_hs |=> (!tx_out.valid) [*2])
        else $error("no gap");
    a_len_byte: assert property (hs && idx_reg == 6'h06 |-> tx_out.data inside {8'h0a, 8'h33})
        else $error("bad length");
    a_last_index: assert property (s_last_hs |-> idx_reg inside {6'h0f, 6'h38})
        else $error("bad size");
    a_maker_bytes: assert property (hs && idx_reg == 6'h04 |-> tx_out.data == MAKER_ID[15:8])
        else $error("bad id");
    a_slave_bit: assert property (hs && idx_reg == 6'h01 |-> tx_out.data[7:6] == 2'b00 && tx_out.data[2])
        else $error("bad status 2");
    a_alarm_resv: assert property (hs && idx_reg == 6'h07 |-> tx_out.data[7:5] == 3'h0)
        else $error("alarm bits");
    a_ident_read: assert property (rd_en_in && addr_in == 8'h08 |=> rd_data_out[15:0] == MAKER_ID)
        else $error("bad ident");
    a_err_pos: assert property (internal_err_in |=> !pos_data_en_out)
        else $error("pos on error");
    a_reject_pos: assert property (evt_in.prm_reject |-> ##2 !pos_data_en_out)
        else $error("pos on reject");
endmodule
bind dpdg_builder dpdg_assertions #(.MAKER_ID(MAKER_ID)) dpdg_assertions_i (.mclk_in, .reset_n_in,
    .addr_in, .rd_en_in, .rd_data_out, .evt_in, .internal_err_in, .diag_req_in, .tx_ready_in,
    .tx_out, .pos_data_en_out);
`default_nettype wire

// *** verification/dpdg_builder_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`define TB_CHK(nm, ex, ac) begin \
    total_checks++; \
    if ((ac) !== (ex)) begin \
        n_errors++; \
        $display("mismatch %s expected %h seen %h", nm, ex, ac); \
    end \
end
// ****
// Bench top
// ****
module dpdg_builder_tb_top;
    localparam logic [15:0] TB_ID = 16'h5a3c; // Arbitrary identifier
    logic mclk = 1'b0;
    logic reset_n, wr_en, rd_en, diag_req, not_ready, wd_on, int_err, slow, clr, pos_en, ready;
    logic [7:0] addr, mst_addr;
    logic [31:0] wdata, rdata, rd_q;
    dpdg_pkg::dpdg_evt_t evt;
    dpdg_pkg::dpdg_ext_t ext;
    dpdg_pkg::dpdg_tx_t tx;
    int n_errors = 0;
    int total_checks = 0;
    logic [7:0] evs [6] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h10, 8'h40};
    logic [31:0] msks [6] = '{32'h10, 32'h2000, 32'h1000, 32'h800008, 32'h4, 32'h140};
    dpdg_builder #(.MAKER_ID(TB_ID)) dpdg_builder_i (.mclk_in(mclk), .reset_n_in(reset_n),
        .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en),
        .rd_data_out(rdata), .evt_in(evt), .prm_master_addr_in(mst_addr),
        .not_ready_in(not_ready), .wd_active_in(wd_on), .internal_err_in(int_err),
        .ext_in(ext), .diag_req_in(diag_req), .tx_ready_in(ready), .tx_out(tx),
        .pos_data_en_out(pos_en));
    dpdg_sink dpdg_sink_i (.mclk_in(mclk), .reset_n_in(reset_n), .tx_in(tx), .slow_in(slow),
        .clear_in(clr), .ready_out(ready));
    // 25 ns clock
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask
    // Read data stands only in the next cycle
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        @(negedge mclk);
        rd_q = rdata;
    endtask
    task automatic stat(input logic [31:0] m, input logic [31:0] e);
        rd(8'h04);
        `TB_CHK("status", e, rd_q & m)
    endtask
    task automatic pulse(input logic [7:0] e);
        @(posedge mclk);
        evt <= dpdg_pkg::dpdg_evt_t'(e);
        @(posedge mclk);
        evt <= '0;
    endtask
    // One telegram, compared byte by byte
    task automatic frame(input logic [7:0] s1, input logic [6:0] n);
        logic [7:0] ex;
        @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        diag_req <= 1'b1;
        @(posedge mclk);
        diag_req <= 1'b0;
        for (int i = 0; i < 2000 && dpdg_sink_i.done_reg !== 1'b1; i++) begin
            @(negedge mclk);
        end
        `TB_CHK("count", n, dpdg_sink_i.cnt_reg)
        for (int k = 0; k < n; k++) begin
            case (k)
                0: ex = s1;
                1: ex = 8'h0c;
                2: ex = 8'h00;
                3: ex = 8'h21;
                4: ex = TB_ID[15:8];
                5: ex = TB_ID[7:0];
                6: ex = 8'(n - 7'd6);
                7: ex = ext.alarms & 8'h1f;
                16: ex = 8'h00;
                default: ex = ext[399 - 8 * (k - 7) -: 8];
            endcase
            `TB_CHK("byte", ex, dpdg_sink_i.mem[k])
        end
        $display("frame of %0d bytes done", n);
    endtask
    // Hang guard
    initial begin
        #(25 * 20000);
        n_errors++;
        $display("watchdog expired");
        end_sim();
    end
    initial begin
        {reset_n, wr_en, rd_en, diag_req, not_ready, wd_on, int_err, slow, clr} = '0;
        {addr, mst_addr, wdata} = '0;
        evt = '0;
        for (int b = 0; b < 50; b++) begin
            ext[8 * b +: 8] = 8'(8'h30 + b);
        end
        ext.alarms = 8'hff;
        ext.add_alarms = 8'hff;
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        stat(32'hffffffff, 32'hff000502);
        `TB_CHK("pos", 1'b0, pos_en)
        rd(8'h08);
        `TB_CHK("ident", {16'h0000, TB_ID}, rd_q)
        rd(8'h10);
        `TB_CHK("unmapped", 32'h0, rd_q)
        $display("reset test done");
        @(posedge mclk);
        wd_on <= 1'b1;
        mst_addr <= 8'h21;
        pulse(8'h80);
        stat(32'hffffffff, 32'h21000c08);
        `TB_CHK("pos", 1'b1, pos_en)
        wr(8'h00, 32'h0);
        frame(8'h08, 7'd16);
        wr(8'h00, 32'h1);
        slow <= 1'b1;
        frame(8'h00, 7'd57);
        wr(8'h00, 32'h2);
        frame(8'h00, 7'd57);
        rd(8'h0c);
        `TB_CHK("length", 32'h0000_0033, rd_q)
        rd(8'h00);
        `TB_CHK("ctrl", 32'h0000_0002, rd_q)
        @(posedge mclk);
        not_ready <= 1'b1;
        wd_on <= 1'b0;
        stat(32'h802, 32'h2);
        @(posedge mclk);
        not_ready <= 1'b0;
        mst_addr <= 8'h33;
        for (int i = 0; i < 6; i++) begin
            pulse(evs[i]);
            stat(msks[i], msks[i]);
        end
        stat(32'hff000000, 32'h21000000);
        $display("event test done");
        @(posedge mclk);
        int_err <= 1'b1;
        stat(32'h208, 32'h208);
        `TB_CHK("pos", 1'b0, pos_en)
        @(posedge mclk);
        int_err <= 1'b0;
        pulse(8'h80);
        stat(32'h200, 32'h200);
        `TB_CHK("pos", 1'b0, pos_en)
        wr(8'h00, 32'h4);
        stat(32'h200, 32'h0);
        `TB_CHK("pos", 1'b1, pos_en)
        $display("error test done");
        end_sim();
    end
endmodule
`default_nettype wire

// *** verification/dpdg_sink.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****
// Master side byte sink
// ****
module dpdg_sink (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire dpdg_pkg::dpdg_tx_t tx_in,
    input wire logic slow_in,
    input wire logic clear_in,
    output logic ready_out
);
    logic [1:0] ph_reg; // Stall phase
    logic [6:0] cnt_reg; // Bytes taken
    logic done_reg; // Last byte seen
    logic [7:0] mem [0:63]; // Raw slave bytes
    // Slow mode takes one byte in four
    assign ready_out = !slow_in || ph_reg == 2'h3;
    // raw bytes, host bits added later
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ph_reg <= 2'h0;
            cnt_reg <= 7'h00;
            done_reg <= 1'b0;
        end else begin
            ph_reg <= ph_reg + 2'h1;
            if (clear_in) begin
                cnt_reg <= 7'h00;
                done_reg <= 1'b0;
            end else if (tx_in.valid && ready_out) begin
                mem[cnt_reg[5:0]] <= tx_in.data;
                cnt_reg <= cnt_reg + 7'h01;
                done_reg <= tx_in.last;
            end
        end
    end
endmodule
`default_nettype wire
